// [bench/cfg_host_model.sv]
`timescale 1ns/100ps
`default_nettype none
module cfg_host_model
(
   input wire logic i_clk_sys,
   input wire logic i_rvalid,
   input wire logic [31:0] i_rdata,
   output logic o_rd,
   output logic o_wr,
   output logic [11:0] o_addr,
   output logic [3:0] o_be,
   output logic [31:0] o_wdata
);
   initial
   begin
      o_rd = 1'b0;
      o_wr = 1'b0;
      o_addr = 12'h000;
      o_be = 4'h0;
      o_wdata = 32'h00000000;
   end

   // Idle lines show the inverse so a stale value cannot pass for a live one
   task automatic release_bus();
      o_rd <= 1'b0;
      o_wr <= 1'b0;
      o_addr <= ~o_addr;
      o_be <= ~o_be;
      o_wdata <= ~o_wdata;
   endtask : release_bus

   task automatic wr(input logic [11:0] a, input logic [3:0] b,
      input logic [31:0] d);
      @(posedge i_clk_sys);
      o_wr <= 1'b1;
      o_addr <= a;
      o_be <= b;
      o_wdata <= d;
      @(posedge i_clk_sys);
      release_bus();
   endtask : wr

   // Answer is registered on the taking edge itself and sampled 1 ns after it
   task automatic rd(input logic [11:0] a, output logic [31:0] d,
      output logic ok);
      @(posedge i_clk_sys);
      o_rd <= 1'b1;
      o_addr <= a;
      @(posedge i_clk_sys);
      release_bus();
      #1;
      ok = i_rvalid;
      d = i_rdata;
   endtask : rd

   // Select write followed by a read of a in the very next cycle
   task automatic wr_rd(input logic [31:0] d, input logic [11:0] a,
      output logic [31:0] q, output logic ok);
      @(posedge i_clk_sys);
      o_wr <= 1'b1;
      o_addr <= 12'h210;
      o_be <= 4'h1;
      o_wdata <= d;
      @(posedge i_clk_sys);
      o_wr <= 1'b0;
      o_rd <= 1'b1;
      o_addr <= a;
      @(posedge i_clk_sys);
      release_bus();
      #1;
      ok = i_rvalid;
      q = i_rdata;
   endtask : wr_rd
endmodule : cfg_host_model
`default_nettype wire

// [bench/test_power_budget_ext_capability.sv]
`timescale 1ns/100ps
`default_nettype none
module test_power_budget_ext_capability;
   logic clk;
   logic rstn;
   logic cfg_rd;
   logic cfg_wr;
   logic [11:0] cfg_addr;
   logic [3:0] cfg_be;
   logic [31:0] cfg_wdata;
   logic ee_load;
   logic [1:0] ee_target;
   logic [31:0] ee_word;
   logic [31:0] rdata;
   logic rvalid;
   logic [31:0] q;
   logic ok;
   int n_errors;
   int n_compared;

   always #5 clk = ~clk;

   power_budget_ext_capability uut
   (
      .i_clk_sys(clk), .i_rstn(rstn), .i_cfg_rd(cfg_rd), .i_cfg_wr(cfg_wr),
      .i_cfg_addr(cfg_addr), .i_cfg_be(cfg_be), .i_cfg_wdata(cfg_wdata),
      .i_ee_load(ee_load), .i_ee_target(ee_target), .i_ee_word(ee_word),
      .o_cfg_rdata(rdata), .o_cfg_rvalid(rvalid)
   );

   cfg_host_model host
   (
      .i_clk_sys(clk), .i_rvalid(rvalid), .i_rdata(rdata), .o_rd(cfg_rd),
      .o_wr(cfg_wr), .o_addr(cfg_addr), .o_be(cfg_be), .o_wdata(cfg_wdata)
   );

   task automatic give_verdict();
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : give_verdict

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      host.rd(a, q, ok);
      chk({31'h0, ok}, 32'h1);
      chk(q, exp);
      @(posedge clk);
      #1;
      chk({31'h0, rvalid}, 32'h0);
   endtask : rd_chk

   task automatic ee(input logic [1:0] t, input logic [31:0] w);
      @(posedge clk);
      ee_load <= 1'b1;
      ee_target <= t;
      ee_word <= w;
      @(posedge clk);
      ee_load <= 1'b0;
      ee_word <= ~w;
   endtask : ee

   task automatic t_defaults();
      rd_chk(12'h20c, 32'h00010004);
      rd_chk(12'h210, 32'h00000000);
      rd_chk(12'h214, 32'h000b8004);
      rd_chk(12'h218, 32'h00000000);
   endtask : t_defaults

   task automatic t_read_only();
      host.wr(12'h20c, 4'hf, 32'hffffffff);
      host.wr(12'h214, 4'hf, 32'hffffffff);
      host.wr(12'h218, 4'hf, 32'hffffffff);
      rd_chk(12'h20c, 32'h00010004);
      rd_chk(12'h214, 32'h000b8004);
      rd_chk(12'h218, 32'h00000000);
   endtask : t_read_only

   task automatic t_select();
      logic [7:0] idx [4] = '{8'h02, 8'h03, 8'h80, 8'hff};
      host.wr(12'h210, 4'hf, 32'hffffff01);
      rd_chk(12'h210, 32'h00000001);
      host.wr(12'h210, 4'he, 32'h00000002);
      rd_chk(12'h210, 32'h00000001);
      host.wr_rd(32'h00000000, 12'h214, q, ok);
      chk(q, 32'h000b8004);
      chk({31'h0, ok}, 32'h1);
      host.wr_rd(32'h00000001, 12'h214, q, ok);
      chk(q, 32'h00098004);
      chk({31'h0, ok}, 32'h1);
      host.wr_rd(32'h00000080, 12'h214, q, ok);
      chk(q, 32'h00000000);
      host.wr_rd(32'h00000003, 12'h210, q, ok);
      chk(q, 32'h00000003);
      foreach (idx[i])
      begin
         host.wr(12'h210, 4'h1, {24'h0, idx[i]});
         rd_chk(12'h214, 32'h00000000);
      end
   endtask : t_select

   task automatic t_autoload();
      host.wr(12'h210, 4'h1, 32'h00000000);
      // Read taken the cycle after the load must already see it
      fork
         ee(2'h0, 32'hfffebe5a);
         begin
            @(posedge clk);
            rd_chk(12'h214, 32'h000aa25a);
         end
      join
      ee(2'h0, 32'hffffffff);
      rd_chk(12'h214, 32'h000be3ff);
      ee(2'h1, 32'h00000000);
      host.wr(12'h210, 4'h1, 32'h00000001);
      rd_chk(12'h214, 32'h00080000);
      // Target 3 must leave every record alone
      ee(2'h3, 32'hffffffff);
      rd_chk(12'h214, 32'h00080000);
      fork
         ee(2'h2, 32'hffffffff);
         begin
            @(posedge clk);
            rd_chk(12'h218, 32'h00000001);
         end
      join
      ee(2'h2, 32'hfffffffe);
      rd_chk(12'h218, 32'h00000000);
   endtask : t_autoload

   task automatic t_second_reset();
      ee(2'h0, 32'h00000001);
      ee(2'h2, 32'h00000001);
      @(posedge clk);
      rstn <= 1'b0;
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      rd_chk(12'h210, 32'h00000000);
      rd_chk(12'h214, 32'h000b8004);
      rd_chk(12'h218, 32'h00000000);
   endtask : t_second_reset

   initial
   begin
      clk = 1'b0;
      rstn = 1'b0;
      ee_load = 1'b0;
      ee_target = 2'h0;
      ee_word = 32'h00000000;
      n_errors = 0;
      n_compared = 0;
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      t_defaults();
      t_read_only();
      t_select();
      t_autoload();
      t_second_reset();
      give_verdict();
   end

   // Whole run needs about 160 cycles
   initial
   begin
      repeat (3000) @(posedge clk);
      n_errors++;
      $display("watchdog expired");
      give_verdict();
   end
endmodule : test_power_budget_ext_capability
`default_nettype wire

// [hw/budget_cap_pkg.sv]
package budget_cap_pkg;

   // Byte offsets in configuration space
   localparam logic [11:0] OFF_CAP_HEADER = 12'h20c;
   localparam logic [11:0] OFF_RECORD_SELECT = 12'h210;
   localparam logic [11:0] OFF_RECORD_DATA = 12'h214;
   localparam logic [11:0] OFF_BUDGET_ALLOC = 12'h218;
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned DATA_W = 32;

   // Capability header fields
   localparam logic [15:0] CAP_IDENTIFIER = 16'h0004;
   localparam logic [3:0] CAP_VERSION = 4'h1;
   localparam logic [11:0] NEXT_POINTER = 12'h000;

   // Record selection
   localparam int unsigned INDEX_W = 8;
   localparam logic [7:0] INDEX_RESET = 8'h00;
   localparam logic [7:0] SEL_MAX = 8'h00;
   localparam logic [7:0] SEL_SUSTAINED = 8'h01;

   // Record field positions
   localparam int unsigned BASE_LSB = 0;
   localparam int unsigned SCALE_LSB = 8;
   localparam int unsigned SUB_LSB = 10;
   localparam int unsigned STATE_LSB = 13;
   localparam int unsigned TYPE_LSB = 15;
   localparam int unsigned RAIL_LSB = 18;
   localparam int unsigned RAIL_MSB = 20;

   // Field defaults
   localparam logic [7:0] BASE_RESET = 8'h04;
   localparam logic [1:0] SCALE_RESET = 2'h0;
   localparam logic [2:0] SUB_RESET = 3'h0;
   localparam logic [1:0] STATE_D0 = 2'h0;
   localparam logic [2:0] TYPE_MAXIMUM = 3'h7;
   localparam logic [2:0] TYPE_SUSTAINED = 3'h3;
   localparam logic [2:0] RAIL_RESET = 3'h2;
   localparam logic ALLOC_RESET = 1'b0;

   // Autoload targets
   localparam logic [1:0] EE_TARGET_MAX = 2'h0;
   localparam logic [1:0] EE_TARGET_SUSTAINED = 2'h1;
   localparam logic [1:0] EE_TARGET_ALLOC = 2'h2;

   function automatic logic [31:0] record_word(input logic [7:0] base,
      input logic [1:0] scale, input logic [2:0] sub,
      input logic [1:0] state, input logic [2:0] kind,
      input logic [2:0] rail);
      record_word = {11'h000, rail, kind, state, sub, scale, base};
   endfunction : record_word

   // Fields that autoload may replace; sub state and rail stay fixed
   localparam logic [31:0] RECORD_LOAD_MASK =
      record_word(8'hff, 2'h3, 3'h0, 2'h3, 3'h7, 3'h0);
   localparam logic [31:0] RECORD_MAX_RESET = record_word(BASE_RESET,
      SCALE_RESET, SUB_RESET, STATE_D0, TYPE_MAXIMUM, RAIL_RESET);
   localparam logic [31:0] RECORD_SUSTAINED_RESET = record_word(BASE_RESET,
      SCALE_RESET, SUB_RESET, STATE_D0, TYPE_SUSTAINED, RAIL_RESET);

   function automatic logic addr_hit(input logic [11:0] addr,
      input logic [11:0] off);
      addr_hit = (addr[11:2] == off[11:2]);
   endfunction : addr_hit

endpackage : budget_cap_pkg

// [hw/budget_record.sv]
`timescale 1ns/100ps
`default_nettype none
module budget_record
   import budget_cap_pkg::*;
#(
   parameter logic [31:0] RESET_WORD = RECORD_MAX_RESET
)
(
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   input wire logic i_load,
   input wire logic [31:0] i_word,
   output logic [31:0] o_word
);

   logic [31:0] word_d;
   logic [31:0] word_q;

   // Masked merge keeps sub state and rail at their fixed codes
   always_comb
   begin
      word_d = word_q;
      if (i_load)
      begin
         word_d = (word_q & ~RECORD_LOAD_MASK) | (i_word & RECORD_LOAD_MASK);
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         word_q <= RESET_WORD;
      end
      else
      begin
         word_q <= word_d;
      end
   end

   assign o_word = word_q;

endmodule : budget_record
`default_nettype wire

// [hw/budget_select.sv]
`timescale 1ns/100ps
`default_nettype none
module budget_select
   import budget_cap_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   input wire logic i_wr,
   input wire logic [11:0] i_addr,
   input wire logic [3:0] i_be,
   input wire logic [7:0] i_wdata,
   output logic [7:0] o_index
);

   logic [7:0] index_d;
   logic [7:0] index_q;

   // Only byte lane 0 carries the index; upper lanes are reserved
   always_comb
   begin
      index_d = index_q;
      if (i_wr && addr_hit(i_addr, OFF_RECORD_SELECT) && i_be[0])
      begin
         index_d = i_wdata;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         index_q <= INDEX_RESET;
      end
      else
      begin
         index_q <= index_d;
      end
   end

   assign o_index = index_q;

endmodule : budget_select
`default_nettype wire

// [hw/power_budget_ext_capability.sv]
`timescale 1ns/100ps
`default_nettype none
module power_budget_ext_capability
   import budget_cap_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   input wire logic i_cfg_rd,
   input wire logic i_cfg_wr,
   input wire logic [11:0] i_cfg_addr,
   input wire logic [3:0] i_cfg_be,
   input wire logic [31:0] i_cfg_wdata,
   input wire logic i_ee_load,
   input wire logic [1:0] i_ee_target,
   input wire logic [31:0] i_ee_word,
   output logic [31:0] o_cfg_rdata,
   output logic o_cfg_rvalid
);

   logic [7:0] index;
   logic [31:0] rec_max;
   logic [31:0] rec_sustained;
   logic load_max;
   logic load_sustained;
   logic alloc_d;
   logic alloc_q;
   logic [31:0] selected;
   logic [31:0] rdata_d;
   logic [31:0] rdata_q;
   logic rvalid_d;
   logic rvalid_q;

   assign load_max = i_ee_load && (i_ee_target == EE_TARGET_MAX);
   assign load_sustained = i_ee_load && (i_ee_target == EE_TARGET_SUSTAINED);

   budget_select u_select (
      .i_clk_sys(i_clk_sys),
      .i_rstn(i_rstn),
      .i_wr(i_cfg_wr),
      .i_addr(i_cfg_addr),
      .i_be(i_cfg_be),
      .i_wdata(i_cfg_wdata[7:0]),
      .o_index(index)
   );

   budget_record #(.RESET_WORD(RECORD_MAX_RESET)) u_rec_max (
      .i_clk_sys(i_clk_sys),
      .i_rstn(i_rstn),
      .i_load(load_max),
      .i_word(i_ee_word),
      .o_word(rec_max)
   );

   budget_record #(.RESET_WORD(RECORD_SUSTAINED_RESET)) u_rec_sustained (
      .i_clk_sys(i_clk_sys),
      .i_rstn(i_rstn),
      .i_load(load_sustained),
      .i_word(i_ee_word),
      .o_word(rec_sustained)
   );

   // Allocation flag: host writes never reach it
   always_comb
   begin
      alloc_d = alloc_q;
      if (i_ee_load && (i_ee_target == EE_TARGET_ALLOC))
      begin
         alloc_d = i_ee_word[0];
      end
   end

   // Record chosen straight from the live index, so no settle time
   always_comb
   begin
      unique case (index)
         SEL_MAX: selected = rec_max;
         SEL_SUSTAINED: selected = rec_sustained;
         default: selected = '0;
      endcase
   end

   // Read mux; writes to read-only words fall through harmlessly
   always_comb
   begin
      rdata_d = rdata_q;
      rvalid_d = i_cfg_rd;
      if (i_cfg_rd)
      begin
         rdata_d = '0;
         if (addr_hit(i_cfg_addr, OFF_CAP_HEADER))
         begin
            rdata_d = {NEXT_POINTER, CAP_VERSION, CAP_IDENTIFIER};
         end
         else if (addr_hit(i_cfg_addr, OFF_RECORD_SELECT))
         begin
            rdata_d = {24'h000000, index};
         end
         else if (addr_hit(i_cfg_addr, OFF_RECORD_DATA))
         begin
            rdata_d = selected;
         end
         else if (addr_hit(i_cfg_addr, OFF_BUDGET_ALLOC))
         begin
            rdata_d = {31'h00000000, alloc_q};
         end
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         alloc_q <= ALLOC_RESET;
         rdata_q <= '0;
         rvalid_q <= 1'b0;
      end
      else
      begin
         alloc_q <= alloc_d;
         rdata_q <= rdata_d;
         rvalid_q <= rvalid_d;
      end
   end

   assign o_cfg_rdata = rdata_q;
   assign o_cfg_rvalid = rvalid_q;

   // Helper signals for the checks below
   logic rd_header;
   logic rd_select;
   logic rd_data;
   logic rd_alloc;
   logic wr_select;
   logic [7:0] wsel;
   logic [31:0] ee_word_q;

   assign rd_header = i_cfg_rd && addr_hit(i_cfg_addr, OFF_CAP_HEADER);
   assign rd_select = i_cfg_rd && addr_hit(i_cfg_addr, OFF_RECORD_SELECT);
   assign rd_data = i_cfg_rd && addr_hit(i_cfg_addr, OFF_RECORD_DATA);
   assign rd_alloc = i_cfg_rd && addr_hit(i_cfg_addr, OFF_BUDGET_ALLOC);
   assign wr_select = i_cfg_wr && addr_hit(i_cfg_addr, OFF_RECORD_SELECT)
      && i_cfg_be[0];
   assign wsel = i_cfg_wdata[7:0];
   assign ee_word_q = i_ee_word;

   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_rstn);

   sequence s_load_max;
      load_max && !i_cfg_wr;
   endsequence

   sequence s_read_max;
      rd_data && (index == SEL_MAX) && !i_ee_load;
   endsequence

   sequence s_write_unsupported;
      wr_select && (wsel > SEL_SUSTAINED) && !i_ee_load;
   endsequence

   a_header_ident: assert property (rd_header |=> o_cfg_rvalid &&
      o_cfg_rdata[15:0] == CAP_IDENTIFIER)
      else $error("capability identifier wrong");

   a_header_version: assert property (rd_header |=>
      o_cfg_rdata[19:16] == CAP_VERSION)
      else $error("capability version wrong");

   a_header_next: assert property (rd_header |=>
      o_cfg_rdata[31:20] == NEXT_POINTER)
      else $error("next pointer not zero");

   a_index_write: assert property (wr_select ##1 rd_select |=>
      o_cfg_rdata == {24'h000000, $past(wsel, 2)})
      else $error("index readback wrong");

   a_index_hold: assert property (i_cfg_wr && !addr_hit(i_cfg_addr,
      OFF_RECORD_SELECT) |=> $stable(index))
      else $error("index changed by foreign write");

   a_record_sustained: assert property (rd_data && index == SEL_SUSTAINED
      && !i_ee_load |=> o_cfg_rdata == rec_sustained)
      else $error("sustained record not shown");

   a_unsupported_zero: assert property (rd_data && index > SEL_SUSTAINED
      |=> o_cfg_rdata == '0)
      else $error("unsupported index not zero");

   a_base_load: assert property (s_load_max ##1 s_read_max |=>
      o_cfg_rdata[SCALE_LSB-1:BASE_LSB] ==
      $past(ee_word_q[SCALE_LSB-1:BASE_LSB], 2))
      else $error("base power not loaded");

   a_scale_load: assert property (s_load_max ##1 s_read_max |=>
      o_cfg_rdata[SUB_LSB-1:SCALE_LSB] ==
      $past(ee_word_q[SUB_LSB-1:SCALE_LSB], 2))
      else $error("scale not loaded");

   a_fixed_fields: assert property (rd_data && index <= SEL_SUSTAINED |=>
      o_cfg_rdata[STATE_LSB-1:SUB_LSB] == SUB_RESET &&
      o_cfg_rdata[RAIL_MSB:RAIL_LSB] == RAIL_RESET &&
      o_cfg_rdata[31:RAIL_MSB+1] == '0)
      else $error("fixed record field wrong");

   a_state_load: assert property (s_load_max ##1 s_read_max |=>
      o_cfg_rdata[TYPE_LSB-1:STATE_LSB] ==
      $past(ee_word_q[TYPE_LSB-1:STATE_LSB], 2))
      else $error("power state not loaded");

   a_type_load: assert property (s_load_max ##1 s_read_max |=>
      o_cfg_rdata[RAIL_LSB-1:TYPE_LSB] ==
      $past(ee_word_q[RAIL_LSB-1:TYPE_LSB], 2))
      else $error("condition type not loaded");

   a_alloc_load: assert property (i_ee_load && i_ee_target ==
      EE_TARGET_ALLOC ##1 rd_alloc && !i_ee_load |=>
      o_cfg_rdata == {31'h00000000, $past(ee_word_q[0], 2)})
      else $error("allocation flag not loaded");

   a_select_follow: assert property (s_write_unsupported ##1 rd_data |=>
      o_cfg_rvalid && o_cfg_rdata == '0)
      else $error("data read ignored new index");

   // No read taken means no answer and no change on the data lines
   sequence s_no_read;
      !i_cfg_rd;
   endsequence

   a_rvalid_follow: assert property (i_cfg_rd |=> o_cfg_rvalid)
      else $error("read not answered");

   a_rvalid_pulse: assert property (s_no_read |=> !o_cfg_rvalid)
      else $error("answer without read");

   a_rdata_hold: assert property (s_no_read |=> $stable(o_cfg_rdata))
      else $error("read data moved without read");

   a_select_reserved: assert property (rd_select |=>
      o_cfg_rdata[31:8] == 24'h000000)
      else $error("select reserved bits set");

   a_index_ignore_be: assert property (i_cfg_wr && !i_cfg_be[0] &&
      addr_hit(i_cfg_addr, OFF_RECORD_SELECT) |=> $stable(index))
      else $error("index written without lane 0");

   a_record_max: assert property (s_read_max |=> o_cfg_rdata == rec_max)
      else $error("maximum record not shown");

   a_data_reserved: assert property (rd_data |=>
      o_cfg_rdata[31:RAIL_MSB+1] == '0)
      else $error("data reserved bits set");

   a_max_fixed: assert property (rec_max[STATE_LSB-1:SUB_LSB] == SUB_RESET
      && rec_max[RAIL_MSB:RAIL_LSB] == RAIL_RESET)
      else $error("maximum record fixed field moved");

   a_sustained_fixed: assert property (rec_sustained[RAIL_MSB:RAIL_LSB] ==
      RAIL_RESET && rec_sustained[STATE_LSB-1:SUB_LSB] == SUB_RESET)
      else $error("sustained record fixed field moved");

   a_max_hold: assert property (!load_max |=> $stable(rec_max))
      else $error("maximum record changed without load");

   a_sustained_hold: assert property (!load_sustained |=>
      $stable(rec_sustained))
      else $error("sustained record changed without load");

   a_alloc_reserved: assert property (rd_alloc |=>
      o_cfg_rdata[31:1] == '0)
      else $error("allocation reserved bits set");

   // Host writes must never reach the flag, only autoload target 2
   a_alloc_hold: assert property (!(i_ee_load && i_ee_target ==
      EE_TARGET_ALLOC) |=> $stable(alloc_q))
      else $error("allocation flag changed without load");

   a_target_ignored: assert property (i_ee_load && i_ee_target >
      EE_TARGET_ALLOC |=> $stable(rec_max) && $stable(alloc_q))
      else $error("ignored target changed state");

endmodule : power_budget_ext_capability
`default_nettype wire
